// ---- hw/sdip_pkg.sv ----
package sdip_pkg;

  // ----------------------------------------------------------------
  // Word format
  // ----------------------------------------------------------------
  localparam int unsigned WORD_BITS    = 16;
  localparam int unsigned WORD_TOP_BIT = 15;
  localparam int unsigned WORD_BOTTOM_BIT = 0;
  localparam logic [15:0] CONV_RESET   = 16'h0000;

  // ----------------------------------------------------------------
  // Link timing
  // ----------------------------------------------------------------
  localparam int unsigned SYS_PERIOD_NS   = 4;
  localparam int unsigned SCLK_MAX_MHZ    = 50;
  localparam int unsigned SCLK_HIGH_MIN_NS = 10;
  localparam int unsigned CS_HOLD_MIN_NS  = 10;
  localparam int unsigned CS_GAP_MIN_NS   = 20;
  // Least times round up to whole system cycles
  localparam int unsigned HALF_MIN_CYC =
    (SCLK_HIGH_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int unsigned PERIOD_MIN_CYC =
    (1000 / SCLK_MAX_MHZ + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int unsigned CS_HOLD_CYC =
    (CS_HOLD_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  localparam int unsigned CS_GAP_CYC =
    (CS_GAP_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  // ----------------------------------------------------------------
  // Controller register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_WORD   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CTRL   = 8'h08;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_LAST_LSB = 16;
  localparam int unsigned CTRL_HALF_LSB = 0;
  localparam int unsigned CTRL_HALF_W   = 8;
  localparam logic [7:0]  CTRL_HALF_RESET = 8'h03;

  // ----------------------------------------------------------------
  // Controller sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_SETUP, ST_HIGH, ST_LOW, ST_HOLD, ST_GAP
  } sdip_state_type;

endpackage

// ---- hw/sdip_link_if.sv ----
`timescale 1ns/1ps
interface sdip_link_if;
  logic frame_sel_n;  // Active-low frame select
  logic sclk;         // Serial clock, made by the controller
  logic sdata;        // Serial data toward the converter

  modport host (output frame_sel_n, output sclk, output sdata);
  modport dev  (input  frame_sel_n, input  sclk, input  sdata);
endinterface

// ---- hw/sdip_host.sv ----
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module sdip_host (
  // System
  input  wire logic        clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Serial link
  sdip_link_if.host        link
);

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic        wr_pend_r;
  logic [7:0]  wr_ofs_r;
  logic [7:0]  half_r;
  logic [15:0] last_r;
  logic        busy_r;
  logic        start;
  logic        accept;

  assign accept = hsel & hready & htrans[1];
  assign start  = wr_pend_r & (wr_ofs_r == sdip_pkg::OFS_WORD) & ~busy_r;

  // Address phase capture
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
      wr_ofs_r  <= 8'h00;
    end else begin
      wr_pend_r <= accept & hwrite;
      wr_ofs_r  <= haddr[7:0];
    end
  end

  // Read data, driven one edge after the address phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (accept & ~hwrite) begin
      case (haddr[7:0])
        sdip_pkg::OFS_STATUS: hrdata <= {last_r, 15'h0000, busy_r};
        sdip_pkg::OFS_CTRL:   hrdata <= {24'h00_0000, half_r};
        default:              hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Zero-wait OKAY answers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Half-period setting, clamped to the fastest legal clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      half_r <= sdip_pkg::CTRL_HALF_RESET;
    end else if (wr_pend_r && wr_ofs_r == sdip_pkg::OFS_CTRL) begin
      if (hwdata[7:0] < 8'(sdip_pkg::HALF_MIN_CYC))
        half_r <= 8'(sdip_pkg::HALF_MIN_CYC);
      else
        half_r <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Serial sequencer
  // ----------------------------------------------------------------
  sdip_pkg::sdip_state_type st_r;
  logic [7:0]  cnt_r;
  logic [3:0]  bit_r;
  logic [15:0] sh_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r             <= sdip_pkg::ST_IDLE;
      cnt_r            <= 8'h00;
      bit_r            <= 4'h0;
      sh_r             <= 16'h0000;
      last_r           <= 16'h0000;
      busy_r           <= 1'b0;
      link.frame_sel_n <= 1'b1;
      link.sclk        <= 1'b0;
      link.sdata       <= 1'b0;
    end else begin
      case (st_r)
        sdip_pkg::ST_IDLE: begin
          if (start) begin
            busy_r           <= 1'b1;
            sh_r             <= hwdata[15:0];
            last_r           <= hwdata[15:0];
            link.frame_sel_n <= 1'b0;
            link.sdata       <= hwdata[15];
            bit_r            <= 4'h0;
            cnt_r            <= half_r;
            st_r             <= sdip_pkg::ST_SETUP;
          end
        end
        sdip_pkg::ST_SETUP, sdip_pkg::ST_LOW: begin
          if (cnt_r > 8'h01) begin
            cnt_r <= cnt_r - 8'h01;
          end else begin
            link.sclk <= 1'b1;
            cnt_r     <= half_r;
            st_r      <= sdip_pkg::ST_HIGH;
          end
        end
        sdip_pkg::ST_HIGH: begin
          if (cnt_r > 8'h01) begin
            cnt_r <= cnt_r - 8'h01;
          end else if (bit_r == 4'hF) begin
            link.sclk <= 1'b0;
            cnt_r     <= 8'(sdip_pkg::CS_HOLD_CYC);
            st_r      <= sdip_pkg::ST_HOLD;
          end else begin
            link.sclk  <= 1'b0;
            link.sdata <= sh_r[14];
            sh_r       <= {sh_r[14:0], 1'b0};
            bit_r      <= bit_r + 4'h1;
            cnt_r      <= half_r;
            st_r       <= sdip_pkg::ST_LOW;
          end
        end
        sdip_pkg::ST_HOLD: begin
          if (cnt_r > 8'h01) begin
            cnt_r <= cnt_r - 8'h01;
          end else begin
            link.frame_sel_n <= 1'b1;
            cnt_r            <= 8'(sdip_pkg::CS_GAP_CYC);
            st_r             <= sdip_pkg::ST_GAP;
          end
        end
        sdip_pkg::ST_GAP: begin
          if (cnt_r > 8'h01) begin
            cnt_r <= cnt_r - 8'h01;
          end else begin
            busy_r <= 1'b0;
            st_r   <= sdip_pkg::ST_IDLE;
          end
        end
        default: st_r <= sdip_pkg::ST_IDLE;
      endcase
    end
  end

endmodule // sdip_host

// ---- hw/sdip_dev.sv ----
`timescale 1ns/1ps
module sdip_dev #(
  parameter int unsigned WIDTH = sdip_pkg::WORD_BITS
) (
  // Power-on reset
  input  wire logic             rst,
  // Serial link
  sdip_link_if.dev              link,
  // Converter side
  output logic [WIDTH-1:0]      conv_code,
  output logic                  word_done,
  output logic [WIDTH-1:0]      shift_word
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The port is defined for one word size only
  if (WIDTH != sdip_pkg::WORD_BITS) begin : g_bad_width
    $error("sdip_dev: WIDTH must equal the word size");
  end

  // ----------------------------------------------------------------
  // Local signals
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] shift_r;      // Input shift register
  logic [WIDTH-1:0] shift_nxt;    // Shift register after one bit
  logic [4:0]       bit_cnt_r;    // Rising edges seen this frame
  logic [4:0]       bit_cnt_nxt;  // Saturating next count
  logic             done_r;       // Word completed this frame
  logic [WIDTH-1:0] conv_r;       // Latched converter register

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Append one serial bit at the bottom, pushing older bits upward
  function automatic logic [WIDTH-1:0] shift_in(
    input logic [WIDTH-1:0] cur,
    input logic             bit_in
  );
    shift_in = {cur[WIDTH-2:0], bit_in};
  endfunction

  // Count rising edges, holding at the word length
  function automatic logic [4:0] count_up(input logic [4:0] cur);
    if (cur >= 5'(WIDTH))
      count_up = cur;
    else
      count_up = cur + 5'h1;
  endfunction

  // ----------------------------------------------------------------
  // Next-value decode
  // ----------------------------------------------------------------
  // The first bit clocked in ends up at the top of the word
  always_comb begin
    shift_nxt   = shift_in(shift_r, link.sdata);
    bit_cnt_nxt = count_up(bit_cnt_r);
  end

  // ----------------------------------------------------------------
  // Input shift register
  // ----------------------------------------------------------------
  // Samples data on the rising serial clock while the frame is open.
  // With frame select high the edge is ignored and the word stays.
  // Extra edges past sixteen keep shifting, so the last sixteen bits
  // of a long frame are what the converter receives.
  always_ff @(posedge link.sclk or posedge rst) begin
    if (rst) begin
      shift_r <= '0;
    end else if (!link.frame_sel_n) begin
      shift_r <= shift_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Frame bit counter
  // ----------------------------------------------------------------
  // Held clear while frame select is high, so the next falling edge
  // of frame select always opens a fresh count. The clock may stand
  // still between frames, hence the asynchronous clear.
  always_ff @(posedge link.sclk or posedge link.frame_sel_n) begin
    if (link.frame_sel_n) begin
      bit_cnt_r <= 5'h0;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Word completion flag
  // ----------------------------------------------------------------
  // Rises on the sixteenth rising edge of the frame, the one that
  // clocks in the bottom bit, and stays up until the frame ends.
  always_ff @(posedge link.sclk or posedge link.frame_sel_n) begin
    if (link.frame_sel_n) begin
      done_r <= 1'b0;
    end else if (bit_cnt_r == 5'(WIDTH - 1)) begin
      done_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Converter register
  // ----------------------------------------------------------------
  // Loaded only on the rising edge of frame select, whether or not
  // the host left frame select low for a while after the word. A
  // short frame still transfers what the shift register holds.
  // Power-on reset leaves the output at zero scale.
  always_ff @(posedge link.frame_sel_n or posedge rst) begin
    if (rst) begin
      conv_r <= sdip_pkg::CONV_RESET;
    end else begin
      conv_r <= shift_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // All straight from flip-flops; nothing leads back onto the link
  assign conv_code  = conv_r;
  assign word_done  = done_r;
  assign shift_word = shift_r;

endmodule // sdip_dev

// ---- dv/sdip_checker.sv ----
`timescale 1ns/1ps
module sdip_checker (
  // System
  input wire logic        clk,
  input wire logic        rst,
  // Link and converter
  input wire logic        frame_sel_n,
  input wire logic        sclk,
  input wire logic        sdata,
  input wire logic [15:0] conv_code,
  input wire logic        word_done,
  input wire logic [15:0] shift_word
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [4:0]  edges_r;
  logic [15:0] shift_q_r;

  // Rising serial edges seen in this frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      edges_r <= 5'h0;
    else if (frame_sel_n)
      edges_r <= 5'h0;
    else if ($rose(sclk))
      edges_r <= edges_r + 5'h1;
  end

  // Shift register as of the previous edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst)
      shift_q_r <= 16'h0;
    else
      shift_q_r <= shift_word;
  end

  // Link timing and device behaviour
  a_idle_clk_low: assert property (frame_sel_n |-> !sclk)
    else $error("serial clock high outside a frame");
  a_select_lead: assert property ($fell(frame_sel_n) |-> !sclk [*3])
    else $error("serial clock too soon after select");
  a_clk_high_min: assert property ($rose(sclk) |-> sclk [*3])
    else $error("serial clock high phase too short");
  a_clk_low_min: assert property ($fell(sclk) |-> !sclk [*3])
    else $error("serial clock low phase too short");
  a_select_gap: assert property ($rose(frame_sel_n) |-> frame_sel_n [*5])
    else $error("select gap too short");
  a_conv_latched: assert property ($changed(conv_code) |-> $rose(frame_sel_n))
    else $error("converter word changed outside select rise");
  a_conv_load: assert property ($rose(frame_sel_n) |-> conv_code == shift_word)
    else $error("converter word not taken from shift register");
  a_done_sixteen: assert property ($rose(word_done) |-> $rose(sclk) && edges_r == 5'hf)
    else $error("word completion not on sixteenth edge");
  a_done_clear: assert property (frame_sel_n |-> !word_done)
    else $error("word completion high outside frame");
  a_shift_msb: assert property ($rose(sclk) && !frame_sel_n |->
    shift_word == {shift_q_r[14:0], sdata})
    else $error("shift register did not take the data bit");
  a_shift_hold: assert property (frame_sel_n |-> $stable(shift_word))
    else $error("shift register moved while deselected");
endmodule // sdip_checker

// ---- dv/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic        clk, rst, hsel, hwrite, hreadyout, hresp, word_done, done_b;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [15:0] conv_code, shift_word, conv_b, shift_b, rx_word;
  int          rx_cnt, err_count, cmp_count;

  sdip_link_if link ();
  sdip_link_if link_b ();
  sdip_host i_sdip_host (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link(link.host));
  sdip_dev i_sdip_dev (.rst(rst), .link(link.dev), .conv_code(conv_code),
    .word_done(word_done), .shift_word(shift_word));
  sdip_dev i_sdip_dev_b (.rst(rst), .link(link_b.dev), .conv_code(conv_b),
    .word_done(done_b), .shift_word(shift_b));
  sdip_checker i_sdip_checker (.clk(clk), .rst(rst), .frame_sel_n(link.frame_sel_n),
    .sclk(link.sclk), .sdata(link.sdata), .conv_code(conv_code), .word_done(word_done),
    .shift_word(shift_word));

  // System clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Word seen on the wire, first bit on top
  always @(negedge link.frame_sel_n) rx_cnt = 0;
  always @(posedge link.sclk) begin
    if (!link.frame_sel_n) begin
      rx_word = {rx_word[14:0], link.sdata};
      rx_cnt++;
    end
  end

  task automatic check(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("mismatch at %0t seen %h expected %h", $time, s, e);
    end
  endtask

  // One single bus transfer, read data left in q
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  // Poll status until the link is idle
  task automatic idle();
    bus(1'b0, sdip_pkg::OFS_STATUS, 32'h0);
    for (int i = 0; i < 300 && q[0] !== 1'b0; i++)
      bus(1'b0, sdip_pkg::OFS_STATUS, 32'h0);
  endtask

  task automatic send(input logic [15:0] w, input logic [15:0] e);
    logic [15:0] old;
    old = conv_code;
    bus(1'b1, sdip_pkg::OFS_WORD, {16'h0, w});
    bus(1'b0, sdip_pkg::OFS_STATUS, 32'h0);
    check(16'(q[0]), 16'h1);
    check(conv_code, old);
    idle();
    check(16'(q[0]), 16'h0);
    check(rx_word, e);
    check(16'(rx_cnt), 16'h10);
    check(conv_code, e);
    check(q[31:16], e);
  endtask

  task automatic test_regs();
    logic [15:0] words [5] = '{16'hA5C3, 16'h8000, 16'h0001, 16'hFFFF, 16'h0000};
    check(conv_code, 16'h0);
    bus(1'b0, sdip_pkg::OFS_CTRL, 32'h0);
    check(q[15:0], 16'h3);
    foreach (words[i]) send(words[i], words[i]);
    bus(1'b1, sdip_pkg::OFS_WORD, 32'h1234);
    send(16'h5AA5, 16'h1234);
    bus(1'b1, sdip_pkg::OFS_CTRL, 32'h1);
    bus(1'b0, sdip_pkg::OFS_CTRL, 32'h0);
    check(q[15:0], 16'h3);
    bus(1'b1, sdip_pkg::OFS_CTRL, 32'h6);
    send(16'h3C5A, 16'h3C5A);
    bus(1'b1, 8'h0C, 32'hFFFF_FFFF);
    bus(1'b0, 8'h0C, 32'h0);
    check(q[15:0], 16'h0);
    check(16'(hresp), 16'h0);
    bus(1'b1, sdip_pkg::OFS_CTRL, 32'h3);
    $display("test registers and words done");
  endtask

  // Far-end driver on the second link
  task automatic lb_bits(input logic [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      link_b.sdata = v[i];
      #3 link_b.sclk = 1'b1;
      #6 link_b.sclk = 1'b0;
      #3;
    end
  endtask

  task automatic lb_end();
    #10 link_b.frame_sel_n = 1'b1;
    link_b.sdata = ~link_b.sdata;
    #24;
  endtask

  task automatic test_far();
    lb_bits(16'h001F, 5);
    check(shift_b, 16'h0);
    link_b.frame_sel_n = 1'b0;
    #5 lb_bits(16'h0055, 7);
    lb_end();
    check(conv_b, 16'h0055);
    link_b.frame_sel_n = 1'b0;
    #5 lb_bits(16'h61D2, 15);
    check(16'(done_b), 16'h0);
    lb_bits(16'h0001, 1);
    check(16'(done_b), 16'h1);
    check(shift_b, 16'hC3A5);
    #30 check(conv_b, 16'h0055);
    lb_bits(16'h0002, 2);
    lb_end();
    check(conv_b, 16'h0E96);
    check(16'(done_b), 16'h0);
    $display("test far end done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Reset, then the scenarios
  initial begin
    // Nonblocking, so every reset process is waiting for the edge
    rst                <= 1'b1;
    hsel               <= 1'b0;
    hwrite             <= 1'b0;
    htrans             <= 2'h0;
    hsize              <= 3'h2;
    haddr              <= 32'h0;
    hwdata             <= 32'h0;
    link_b.frame_sel_n <= 1'b1;
    link_b.sclk        <= 1'b0;
    link_b.sdata       <= 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    test_regs();
    test_far();
    print_verdict();
  end

  // Watchdog, far beyond the few microseconds of traffic
  initial begin
    #100000;
    err_count++;
    print_verdict();
  end
endmodule // tb
